/* core/lsp_core.sv */
// lamp switch control core: mode decode, spi slave, pwm with delays,
// external clock monitor and internal clock calibration.
// assumes analog flags arrive asynchronously and spi runs on its own clock.
`timescale 1ns/1ns
`default_nettype none
module lsp_core
  import lsp_pkg::*;
#(
  parameter int WDOG_CYC = 50000
)(
  // system
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              clk_en_i,
  // spi link
  input  wire logic              sclk_i,
  input  wire logic              chip_select_n_i,
  input  wire logic              si_i,
  output logic                   so_o,
  output logic                   so_oe_n_o,
  // pins
  input  wire logic              reset_wake_n_i,
  input  wire logic              wake_i,
  input  wire logic              failsafe_strap_in_i,
  input  wire logic [CH_N-1:0]   parallel_in_i,
  input  wire logic              vdd_fail_i,
  // analog flags
  input  wire logic [CH_N-1:0]   overcurrent_flag_i,
  input  wire logic [CH_N-1:0]   overtemp_flag_i,
  input  wire logic [CH_N-1:0]   severe_short_flag_i,
  input  wire logic              undervoltage_flag_i,
  input  wire logic              overvoltage_flag_i,
  // outputs
  output logic [CH_N-1:0]        switch_out_o,
  output logic                   fault_flag_n_o,
  output logic                   normal_mode_flag_o,
  output logic                   clock_fail_o,
  output logic [3:0]             mode_o
);
  // refuse a watchdog count that the timeout compare cannot serve
  if (WDOG_CYC < 2)
  begin : g_wdog_chk
    $error("watchdog count too small");
  end

  // spi link domain
  logic [WORD_W-1:0] sh_in_q;
  logic [WORD_W-1:0] stat_word;
  logic              sck_tog_q;

  // shift in on falling edge while selected, chip select clears the shift register
  always_ff @(negedge sclk_i or posedge chip_select_n_i)
  begin
    if (chip_select_n_i)
      sh_in_q <= '0;
    else
      sh_in_q <= {sh_in_q[WORD_W-2:0], si_i};
  end

  // serial out: first bit from status, then status bits picked by the out counter
  logic first_q;
  always_ff @(posedge sclk_i or posedge chip_select_n_i)
  begin
    if (chip_select_n_i)
      first_q <= 1'b1;
    else
      first_q <= 1'b0;
  end
  logic [WORD_W-1:0] stat_cap_q;
  // status captured at chip select fall from synchronised state
  always_ff @(negedge chip_select_n_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      stat_cap_q <= '0;
    else
      stat_cap_q <= stat_word;
  end
  logic [4:0] so_cnt_q;
  always_ff @(posedge sclk_i or posedge chip_select_n_i)
  begin
    if (chip_select_n_i)
      so_cnt_q <= '0;
    else
      so_cnt_q <= so_cnt_q + 5'h01;
  end
  logic so_bit_q;
  always_ff @(posedge sclk_i or posedge chip_select_n_i)
  begin
    if (chip_select_n_i)
      so_bit_q <= 1'b0;
    else
      so_bit_q <= stat_cap_q[4'(WORD_W - 1) - so_cnt_q[3:0]];
  end
  always_comb
  begin
    so_o      = first_q ? stat_cap_q[WORD_W-1] : so_bit_q;
    so_oe_n_o = chip_select_n_i;
  end
  // note: so comes from link flops and the select pin, not ref_clk flops

  // word latch on chip select rise, toggled to hand over
  logic [WORD_W-1:0] word_q;
  always_ff @(posedge chip_select_n_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      word_q    <= '0;
      sck_tog_q <= 1'b0;
    end
    else
    begin
      word_q    <= sh_in_q;
      sck_tog_q <= ~sck_tog_q;
    end
  end

  // synchronisers
  logic [2:0] tog_s;
  logic [1:0] cs_s;
  logic [CH_N-1:0] in_s1, in_s2;
  logic [9:0] pin_s1, pin_s2;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tog_s  <= '0;
      cs_s   <= 2'h3;
      in_s1  <= '0;
      in_s2  <= '0;
      pin_s1 <= '0;
      pin_s2 <= '0;
    end
    else if (clk_en_i)
    begin
      tog_s  <= {tog_s[1:0], sck_tog_q};
      cs_s   <= {cs_s[0], chip_select_n_i};
      in_s1  <= parallel_in_i;
      in_s2  <= in_s1;
      pin_s1 <= {vdd_fail_i, failsafe_strap_in_i, wake_i, ~reset_wake_n_i,
                 undervoltage_flag_i, overvoltage_flag_i, 4'h0};
      pin_s2 <= pin_s1;
    end
  end
  logic [CH_N-1:0] flag_s1, flag_s2;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      flag_s1 <= '0;
      flag_s2 <= '0;
    end
    else if (clk_en_i)
    begin
      flag_s1 <= overcurrent_flag_i | overtemp_flag_i | severe_short_flag_i;
      flag_s2 <= flag_s1;
    end
  end
  wire word_evt = tog_s[2] ^ tog_s[1];
  wire [4:0] waddr = word_q[ADDR_MSB -: ADDR_W];

  // mode terms
  wire       vdd_fail = pin_s2[9];
  wire       strap_op = pin_s2[8];
  wire       wake     = pin_s2[7] | ~pin_s2[6] | (|in_s2);
  logic [9:0]       ctrl_q;
  logic [CH_N-1:0]  on_q;
  logic [9:0]       duty_q [CH_N];
  logic             wdog_to_q;
  logic             vfail_q;
  wire chan_fault = |flag_s2;
  wire fail  = vfail_q | (vdd_fail & ctrl_q[CTRL_VDD_EN]) | (wdog_to_q & strap_op);
  wire fault = chan_fault | pin_s2[5] | (pin_s2[4] & ctrl_q[CTRL_OV_GATE]);
  lsp_mode_e mode_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      mode_q <= MODE_SLEEP;
    else if (clk_en_i)
    begin
      if (!wake)
        mode_q <= MODE_SLEEP;
      else if (fault)
        mode_q <= MODE_FAULT;
      else if (fail)
        mode_q <= MODE_FSAFE;
      else
        mode_q <= MODE_NORMAL;
    end
  end
  // supply loss held until the supply returns and a word with bit 15 set arrives, since fail-safe clears its enable
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      vfail_q <= 1'b0;
    else if (clk_en_i)
    begin
      if (!wake)
        vfail_q <= 1'b0;
      else if (vdd_fail && ctrl_q[CTRL_VDD_EN])
        vfail_q <= 1'b1;
      else if (!vdd_fail && word_evt && word_q[WORD_W-1])
        vfail_q <= 1'b0;
    end
  end
  wire defaults = (mode_q == MODE_SLEEP) || (mode_q == MODE_FSAFE);

  // register writes; sleep and fail-safe clear the control, on and duty registers, not the calibrated divider
  logic cal_arm_q;
  logic cal_done;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_q    <= CFG_RST;
      on_q      <= '0;
      cal_arm_q <= 1'b0;
      for (int i = 0; i < CH_N; i++)
        duty_q[i] <= CFG_RST;
    end
    else if (clk_en_i)
    begin
      if (defaults)
      begin
        ctrl_q    <= CFG_RST;
        on_q      <= '0;
        cal_arm_q <= 1'b0;
        for (int i = 0; i < CH_N; i++)
          duty_q[i] <= CFG_RST;
      end
      else if (word_evt)
      begin
        cal_arm_q <= (waddr == ADDR_CALIBRATION_CMD);
        if (waddr == ADDR_CTRL)
          ctrl_q <= word_q[9:0];
        if (waddr == ADDR_ON)
          on_q <= word_q[CH_N-1:0];
        for (int i = 0; i < CH_N; i++)
          if (waddr == ADDR_DUTY0 + 5'(i))
            duty_q[i] <= word_q[9:0];
      end
      else if (cal_done)
        cal_arm_q <= 1'b0;
    end
  end

  // watchdog: bit 15 must toggle within the window while the strap is open
  logic [$clog2(WDOG_CYC+1)-1:0] wd_cnt_q;
  logic wd_bit_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wd_cnt_q  <= '0;
      wd_bit_q  <= 1'b0;
      wdog_to_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (!wake || !strap_op)
      begin
        wd_cnt_q  <= '0;
        wdog_to_q <= 1'b0;
      end
      else if (word_evt && (word_q[WORD_W-1] != wd_bit_q || wdog_to_q))
      begin
        wd_bit_q <= word_q[WORD_W-1];
        wd_cnt_q <= '0;
        if (word_q[WORD_W-1])
          wdog_to_q <= 1'b0;
      end
      else if (mode_q == MODE_NORMAL)
      begin
        if (wd_cnt_q == ($clog2(WDOG_CYC+1))'(WDOG_CYC))
          wdog_to_q <= 1'b1;
        else
          wd_cnt_q <= wd_cnt_q + 1'b1;
      end
    end
  end

  // calibration: count cycles of the chip select low pulse
  logic [12:0] cal_cnt_q;
  logic [12:0] cal_div_q;
  wire cs_low = ~cs_s[1];
  logic cs_low_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cal_cnt_q <= '0;
      cal_div_q <= CAL_DEF;
      cs_low_q  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      cs_low_q <= cs_low;
      if (cal_arm_q && cs_low && cal_cnt_q != 13'h1fff)
        cal_cnt_q <= cal_cnt_q + 13'h0001;
      else if (!cal_arm_q)
        cal_cnt_q <= '0;
      if (cal_done && cal_cnt_q >= 13'(CAL_MIN_CYC) && cal_cnt_q <= 13'(CAL_MAX_CYC))
        cal_div_q <= cal_cnt_q;
    end
  end
  assign cal_done = cal_arm_q && cs_low_q && !cs_low;

  // internal pwm tick: one per calibrated divider
  logic [12:0] div_q;
  logic        int_tick;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      div_q <= '0;
    else if (clk_en_i)
      div_q <= (div_q >= cal_div_q - 13'h0001) ? 13'h0000 : div_q + 13'h0001;
  end
  assign int_tick = (div_q == 13'h0000);

  // external clock monitor on input zero rising edges
  logic in0_q;
  logic [12:0] mon_q;
  logic clk_fail_q;
  wire ext_tick = in_s2[0] & ~in0_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      in0_q      <= 1'b0;
      mon_q      <= '0;
      clk_fail_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      in0_q <= in_s2[0];
      if (ext_tick)
      begin
        clk_fail_q <= (mon_q < 13'(EXT_MIN_CYC));
        mon_q      <= '0;
      end
      else if (mon_q > 13'(EXT_MAX_CYC))
        clk_fail_q <= 1'b1;
      else
        mon_q <= mon_q + 13'h0001;
    end
  end
  wire use_int = ctrl_q[CTRL_CLK_SEL];
  wire pwm_tick = use_int ? int_tick : ext_tick;
  wire clk_bad  = ~use_int & clk_fail_q;
  wire pwm_on   = ctrl_q[CTRL_PWM_EN] & ~clk_bad;

  // shared period counter; channels offset by their delay code
  logic [DUTY_W-1:0] per_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      per_q <= '0;
    else if (clk_en_i && pwm_tick)
      per_q <= per_q + 7'h01;
  end

  function automatic logic duty_hi(input logic [6:0] cnt, input logic [9:0] cfg);
    logic [6:0] ph;
    ph = cnt - 7'(cfg[DLY_LSB +: DLY_W] * DLY_STEP);
    duty_hi = (cfg[DUTY_LSB +: DUTY_W] == 7'h7f) || (ph <= cfg[DUTY_LSB +: DUTY_W]);
  endfunction

  // output command and fault latch per channel
  logic [CH_N-1:0] fc_q, latch_q;
  logic [CH_N-1:0] hson, fctl;
  always_comb
  begin
    for (int i = 0; i < CH_N; i++)
    begin
      fctl[i] = (in_s2[i] & ~ctrl_q[CTRL_DIRDIS] & ~ctrl_q[CTRL_PWM_EN]) | on_q[i];
      if (mode_q == MODE_FSAFE)
        hson[i] = in_s2[i];
      else if (pwm_on)
        hson[i] = on_q[i] & duty_hi(per_q, duty_q[i]);
      else if (ctrl_q[CTRL_PWM_EN])
        hson[i] = on_q[i];
      else
        hson[i] = on_q[i] | (in_s2[i] & ~ctrl_q[CTRL_DIRDIS]);
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      fc_q    <= '0;
      latch_q <= '0;
    end
    else if (clk_en_i)
    begin
      fc_q <= fctl;
      for (int i = 0; i < CH_N; i++)
        if (flag_s2[i])
          latch_q[i] <= 1'b1;  // set wins
        else if (fctl[i] != fc_q[i] && mode_q != MODE_SLEEP)
          latch_q[i] <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      switch_out_o       <= '0;
      fault_flag_n_o     <= 1'b1;
      normal_mode_flag_o <= 1'b0;
      clock_fail_o       <= 1'b0;
      mode_o             <= 4'h1;
    end
    else if (clk_en_i)
    begin
      switch_out_o       <= (mode_q == MODE_SLEEP) ? '0 : hson & ~latch_q;
      fault_flag_n_o     <= ~(fault | (|latch_q));
      normal_mode_flag_o <= (mode_q == MODE_NORMAL);
      clock_fail_o       <= clk_bad;
      mode_o             <= mode_q;
    end
  end

  // status word returned on the next transfer
  assign stat_word = {normal_mode_flag_o, mode_q[3], clk_bad, latch_q,
                      ctrl_q[4:0], switch_out_o};
endmodule
`default_nettype wire

/* include/lsp_pkg.sv */
// constants for the lamp switch pwm control core
// assumes a 50 MHz system clock and a slower spi link clock
package lsp_pkg;
  localparam int          CH_N         = 4;
  localparam int          WORD_W       = 16;
  localparam int          ADDR_W       = 5;
  localparam int          DUTY_W       = 7;
  localparam int          DLY_W        = 3;
  localparam int          PWM_STEPS    = 128;
  localparam logic [6:0]  DLY_STEP     = 7'h10;
  // register addresses carried in bits 14:10 of each word
  localparam logic [4:0]  ADDR_CTRL    = 5'h01;
  localparam logic [4:0]  ADDR_ON      = 5'h02;
  localparam logic [4:0]  ADDR_DUTY0   = 5'h04;
  localparam logic [4:0]  ADDR_CALIBRATION_CMD    = 5'h0f;
  localparam int          ADDR_MSB     = 14;
  // control register field positions
  localparam int          CTRL_PWM_EN  = 0;
  localparam int          CTRL_CLK_SEL = 1;
  localparam int          CTRL_VDD_EN  = 2;
  localparam int          CTRL_OV_GATE = 3;
  localparam int          CTRL_DIRDIS  = 4;
  // duty register: duty in 6:0, delay in 9:7
  localparam int          DUTY_LSB     = 0;
  localparam int          DLY_LSB      = 7;
  // reset values
  localparam logic [9:0]  CFG_RST      = 10'h000;
  // internal clock calibration, counted in system clock cycles
  localparam int          CAL_MIN_NS   = 14000;
  localparam int          CAL_MAX_NS   = 130000;
  localparam int          CLK_NS       = 20;
  localparam int          CAL_MIN_CYC  = (CAL_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CAL_MAX_CYC  = CAL_MAX_NS / CLK_NS;
  localparam logic [12:0] CAL_DEF      = 13'h0271;
  // external clock monitor window, system cycles per pwm clock period
  localparam int          EXT_MIN_NS   = 14000;
  localparam int          EXT_MAX_NS   = 130000;
  localparam int          EXT_MIN_CYC  = (EXT_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int          EXT_MAX_CYC  = EXT_MAX_NS / CLK_NS;
  typedef enum logic [3:0] {
    MODE_SLEEP  = 4'b0001,
    MODE_NORMAL = 4'b0010,
    MODE_FSAFE  = 4'b0100,
    MODE_FAULT  = 4'b1000
  } lsp_mode_e;
endpackage

/* test/lsp_chk.sv */
// port checker for the lamp switch control core
// assumes it is bound to lsp_core and that clk_en_i is held high
`timescale 1ns/1ns
`default_nettype none
module lsp_chk
  import lsp_pkg::*;
(
  // system
  input wire logic            ref_clk_i,
  input wire logic            rst_b_i,
  // link and pins
  input wire logic            chip_select_n_i,
  input wire logic            so_oe_n_o,
  input wire logic            reset_wake_n_i,
  input wire logic            wake_i,
  input wire logic [CH_N-1:0] parallel_in_i,
  input wire logic [CH_N-1:0] overcurrent_flag_i,
  // outputs
  input wire logic [CH_N-1:0] switch_out_o,
  input wire logic            fault_flag_n_o,
  input wire logic            normal_mode_flag_o,
  input wire logic [3:0]      mode_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // no wake term at all, and a channel flag raised while awake
  logic quiet;
  logic hit;
  assign quiet = !reset_wake_n_i && !wake_i && parallel_in_i == '0;
  assign hit = reset_wake_n_i && |overcurrent_flag_i;
  // serial output released exactly while deselected
  chk_so_release: assert property (so_oe_n_o == chip_select_n_i)
    else $error("serial out enable differs from select");
  chk_mode_onehot: assert property ($onehot(mode_o))
    else $error("mode is not one-hot");
  chk_nm_flag: assert property (normal_mode_flag_o == (mode_o == MODE_NORMAL))
    else $error("normal flag disagrees with mode");
  chk_sleep_entry: assert property (quiet [*5] |-> mode_o == MODE_SLEEP)
    else $error("no wake term but not asleep");
  chk_sleep_off: assert property ((mode_o == MODE_SLEEP) [*2] |-> switch_out_o == '0)
    else $error("output on in sleep");
  chk_fault_entry: assert property (hit [*5] |-> mode_o == MODE_FAULT)
    else $error("channel flag but no fault mode");
  chk_fault_pin: assert property ((mode_o == MODE_FAULT) |-> $past(!fault_flag_n_o))
    else $error("fault pin high in fault mode");
  chk_fault_kill: assert property ((hit && $stable(overcurrent_flag_i)) [*5]
    |-> (switch_out_o & overcurrent_flag_i) == '0)
    else $error("faulted channel still on");
  chk_fsafe_follow: assert property ((mode_o == MODE_FSAFE && $stable(parallel_in_i)) [*4]
    |-> switch_out_o == parallel_in_i)
    else $error("fail-safe output not following input");
endmodule
bind lsp_core lsp_chk lsp_chk_i (
  .ref_clk_i, .rst_b_i, .chip_select_n_i, .so_oe_n_o, .reset_wake_n_i, .wake_i,
  .parallel_in_i, .overcurrent_flag_i, .switch_out_o, .fault_flag_n_o,
  .normal_mode_flag_o, .mode_o
);
`default_nettype wire

/* test/lsp_mcu.sv */
// controller model acting as spi master on the link
// assumes the core samples on falling and shifts out on rising clock
`timescale 1ns/1ns
`default_nettype none
module lsp_mcu
(
  // spi link
  output logic      sclk_o,
  output logic      chip_select_n_o,
  output logic      si_o,
  input  wire logic so_i
);
  // link idles with clock low and select high
  initial
  begin
    sclk_o = 1'b0;
    chip_select_n_o = 1'b1;
    si_o = 1'b0;
  end
  // one whole word, msb first both ways, 64 ns clock only inside the frame
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    chip_select_n_o = 1'b0;
    #84;
    for (int i = 15; i >= 0; i--)
    begin
      #16 si_o = w[i];
      #16 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
      r[i] = so_i;
    end
    #100 chip_select_n_o = 1'b1;
    si_o = ~si_o; // stale data line no longer shows the last bit
    #200;
  endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the lamp switch control core
// assumes the controller model on the link and the bound port checker
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import lsp_pkg::*;
;
  // clocks, pins and counters
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        sclk, cs_n, si, so, so_oe_n, flt_n, nm, cfail;
  logic        rw_n = 1'b0;
  logic        vdd = 1'b0;
  logic        wake = 1'b0;
  logic        strap = 1'b0;
  logic        uv = 1'b0;
  logic [3:0]  pin = '0;
  logic [3:0]  oc = '0;
  logic [3:0]  ot = '0;
  logic [3:0]  sw, mode;
  logic [15:0] rx;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cyc = 0;
  // 50 MHz system clock
  always #10 ref_clk = ~ref_clk;
  lsp_mcu lsp_mcu_i (.sclk_o(sclk), .chip_select_n_o(cs_n), .si_o(si), .so_i(so));
  lsp_core #(.WDOG_CYC(20)) lsp_core_i (
    .ref_clk_i(ref_clk), .rst_b_i(rst_b), .clk_en_i(1'b1),
    .sclk_i(sclk), .chip_select_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n),
    .reset_wake_n_i(rw_n), .wake_i(wake), .failsafe_strap_in_i(strap),
    .parallel_in_i(pin), .vdd_fail_i(vdd), .overcurrent_flag_i(oc),
    .overtemp_flag_i(ot), .severe_short_flag_i(4'h0),
    .undervoltage_flag_i(uv), .overvoltage_flag_i(1'b0),
    .switch_out_o(sw), .fault_flag_n_o(flt_n), .normal_mode_flag_o(nm),
    .clock_fail_o(cfail), .mode_o(mode)
  );
  // bench helpers
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] wd(input logic [4:0] a, input logic [9:0] d);
    return {1'b1, a, d};
  endfunction
  task automatic wr(input logic [15:0] w);
    lsp_mcu_i.xfer(w, rx);
    step(10);
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // each wake term alone leaves sleep
  task automatic t_wake;
    chk("reset mode", 16'(mode), 16'(MODE_SLEEP));
    chk("reset fault pin", 16'(flt_n), 16'h0001);
    for (int i = 0; i < 6; i++)
    begin
      rw_n = (i == 0);
      wake = (i == 1);
      pin = (i > 1) ? 4'(1 << (i - 2)) : 4'h0;
      step(6);
      chk("wake mode", 16'(mode), 16'(MODE_NORMAL));
      chk("nm flag", 16'(nm), 16'h0001);
      chk("direct out", 16'(sw), 16'(pin));
      rw_n = 1'b0;
      wake = 1'b0;
      pin = '0;
      step(6);
      chk("sleep mode", 16'(mode), 16'(MODE_SLEEP));
    end
    $display("test wake done");
  endtask
  // on bits, status readback, unmapped address, direct disable
  task automatic t_spi;
    wr(wd(ADDR_ON, 10'h00a));
    chk("on bits", 16'(sw), 16'h000a);
    wr(wd(5'h1f, 10'h3ff));
    chk("status", rx, 16'ha00a);
    wr(wd(ADDR_ON, 10'h000));
    chk("status unmapped", rx, 16'ha00a);
    pin = 4'h5;
    wr(wd(ADDR_CTRL, 10'h010));
    chk("dir disabled", 16'(sw), 16'h0000);
    wr(wd(ADDR_CTRL, 10'h000));
    chk("dir enabled", 16'(sw), 16'h0005);
    pin = '0;
    $display("test spi done");
  endtask
  // pwm on with no external clock, then internal clock selected
  task automatic t_clk;
    int k;
    k = 0;
    pin = 4'h8;
    wr(wd(ADDR_ON, 10'h003));
    wr(wd(ADDR_CTRL, 10'h001));
    while (cfail !== 1'b1 && k < 8000)
    begin
      step(1);
      k++;
    end
    chk("clock fail", 16'(cfail), 16'h0001);
    chk("on bits only", 16'(sw), 16'h0003);
    wr(wd(ADDR_CTRL, 10'h003));
    chk("fail status", rx, 16'ha013);
    chk("internal clock", 16'(cfail), 16'h0000);
    wr(wd(ADDR_CTRL, 10'h000));
    wr(wd(ADDR_ON, 10'h000));
    pin = '0;
    $display("test clock done");
  endtask
  // latched channel fault, cleared here by toggling its on bit
  task automatic t_fault;
    wr(wd(ADDR_ON, 10'h002));
    oc = 4'h2;
    step(6);
    chk("fault mode", 16'(mode), 16'(MODE_FAULT));
    chk("fault out", 16'(sw), 16'h0000);
    oc = '0;
    step(6);
    chk("latched pin", 16'(flt_n), 16'h0000);
    chk("latched out", 16'(sw), 16'h0000);
    wr(wd(ADDR_ON, 10'h000));
    wr(wd(ADDR_ON, 10'h002));
    chk("cleared pin", 16'(flt_n), 16'h0001);
    chk("cleared out", 16'(sw), 16'h0002);
    ot = 4'h4;
    step(6);
    chk("temp fault", 16'(mode), 16'(MODE_FAULT));
    ot = '0;
    uv = 1'b1;
    step(6);
    chk("uv fault", 16'(mode), 16'(MODE_FAULT));
    uv = 1'b0;
    wr(wd(ADDR_ON, 10'h000));
    $display("test fault done");
  endtask
  // watchdog timeout with open strap gives fail-safe
  task automatic t_fsafe;
    int k;
    k = 0;
    pin = 4'h6;
    wr(wd(ADDR_ON, 10'h001));
    strap = 1'b1;
    while (mode !== MODE_FSAFE && k < 300)
    begin
      step(1);
      k++;
    end
    step(6);
    chk("fsafe mode", 16'(mode), 16'(MODE_FSAFE));
    chk("fsafe nm", 16'(nm), 16'h0000);
    chk("fsafe out", 16'(sw), 16'h0006);
    pin = 4'h9;
    wr({1'b0, ADDR_ON, 10'h00f});
    chk("write refused", 16'(sw), 16'h0009);
    strap = 1'b0;
    step(6);
    chk("back normal", 16'(mode), 16'(MODE_NORMAL));
    chk("defaults", 16'(sw), 16'h0009);
    wr(wd(ADDR_CTRL, 10'h004));
    vdd = 1'b1;
    step(6);
    chk("supply fsafe", 16'(mode), 16'(MODE_FSAFE));
    chk("supply out", 16'(sw), 16'h0009);
    vdd = 1'b0;
    step(6);
    chk("supply held", 16'(mode), 16'(MODE_FSAFE));
    wr(wd(ADDR_ON, 10'h000));
    chk("supply cleared", 16'(mode), 16'(MODE_NORMAL));
    $display("test fsafe done");
  endtask
  // cycle ceiling against a hang
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      $display("timeout");
      conclude();
    end
  end
  // reset then the scenarios
  initial
  begin
    repeat (12) @(posedge ref_clk);
    #2 rst_b = 1'b1;
    t_wake();
    rw_n = 1'b1;
    step(6);
    t_spi();
    t_clk();
    t_fault();
    t_fsafe();
    conclude();
  end
endmodule
`default_nettype wire
